/* rtl/async_serial_tx_map.svh */
/*
 * Register map, field positions, reset values and tick counts
 * of the serial transmitter. Assumes an APB master on pclk and
 * word registers: byte address = register index * 4.
 */
// Operation
// - Frame is start, 8/9 data, stop
// - Length bit clear: 8 data, 10 bits
// - Length bit set: 9 data, 11 bits
// - Ninth bit from sticky high data field
// - Parity/address bit sits in data MSB
// - Normal coding is NRZ mark/space
// - Infrared: zero is pulse, one low
// - One 16-bit modulus counter sets timing
// - Divisor 0..65535, integer only, no fine part
// - Sample rate is bus clock over divisor
// - Transmit bit lasts sixteen sample ticks
// - Receiver gets sixteen samples per bit
// - Divisor zero stops the baud generator
// - High baud write waits for low write
// - Enable rise queues a preamble first
// - Buffer moves to shifter, framed, sent
// - Each buffer transfer sets empty flag
// - Empty flag resets to one
// - New send only after flag cleared
// - Break detect, collision abort, cancel
// - Preamble is ten or eleven ones
// - Next load nine sixteenths into stop
// - Line idles at one without frame; infrared txd idles low
`ifndef ASYNC_SERIAL_TX_MAP_SVH
`define ASYNC_SERIAL_TX_MAP_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_BAUD_HIGH   5'h00
`define IDX_BAUD_LOW    5'h01
`define IDX_CTRL_ONE    5'h02
`define IDX_CTRL_TWO    5'h03
`define IDX_STATUS_ONE  5'h04
`define IDX_LINE_CTRL   5'h05
`define IDX_DATA_HIGH   5'h06
`define IDX_DATA_LOW    5'h07
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CR2_TE          3
`define SR1_TX_BUFFER_EMPTY_FLAG        7
`define SR1_TC          6
`define SR1_BRK         1
`define SR1_BERR        0
`define LC_INFRARED_ENABLE         0
`define LC_BERRE        1
`define DH_T8           6
`define REG_RESET       8'h00
`define DIV_RESET       16'h0000
// ----------------------------------------
// Tick counts within one bit, bits per frame, break sample limits
// ----------------------------------------
`define LAST_TICK       4'hF
`define STOP_LOAD_TICK  4'h8
`define CHECK_TICK      4'h8
`define IR_FIRST_TICK   4'h7
`define IR_LAST_TICK    4'h9
`define FRAME_LEN8      4'hA
`define FRAME_LEN9      4'hB
`define BRK_LAST8       8'h9F
`define BRK_LAST9       8'hAF
`endif

/* rtl/async_serial_tx_pkg.sv */
/*
 * Types shared by the serial transmitter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package async_serial_tx_pkg;
    // Transmit sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_PREAMBLE,
        ST_FRAME
    } tx_state_t;
    // First control register layout
    typedef struct packed {
        logic loopback_select;
        logic reserved6;
        logic receive_source_select;
        logic char_len9;
        logic wake_select;
        logic idle_type_select;
        logic parity_enable_bit;
        logic parity_type_bit;
    } ctrl_one_t;
endpackage

/* rtl/async_serial_tx.sv */
/*
 * Serial transmitter with baud generator, APB register file,
 * break detection and bit-level collision abort.
 * Assumes an APB master on pclk and an rxd pin that is
 * asynchronous to pclk.
 */
// Decided for this implementation: the APB register port and the address map.
`include "async_serial_tx_map.svh"

module async_serial_tx
    import async_serial_tx_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rxd,
    output logic             txd,
    output logic             rx_sample_tick
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------

    // Word-aligned, in range
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'h0) && (a[7:5] == 3'h0);
    endfunction

    // Data bits, framed LSB first; parity in the data MSB
    function automatic logic [10:0] build_frame(
        input logic [7:0] d,
        input logic       t8,
        input logic       len9,
        input logic       pe,
        input logic       pt
    );
        logic [8:0] dat;
        logic       par;
        dat = {t8, d};
        par = len9 ? ((^d) ^ pt) : ((^d[6:0]) ^ pt);
        if (pe && len9) begin
            dat[8] = par;
        end else if (pe) begin
            dat[7] = par;
        end
        if (len9) begin
            build_frame = {1'b1, dat, 1'b0};
        end else begin
            build_frame = {2'b11, dat[7:0], 1'b0};
        end
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic        pready_q;      // Access answered
    logic        pslverr_q;     // Unmapped address
    logic [31:0] prdata_q;      // Read data
    logic [7:0]  rdata_d;       // Read mux
    logic [7:0]  baud_hi_q;     // Staged divisor high byte
    logic [7:0]  baud_lo_q;     // Low byte as written
    logic [15:0] div_q;         // Divisor in use
    ctrl_one_t   ctrl_one_q;    // Length, parity, misc
    logic [7:0]  ctrl_two_q;    // Enables
    logic [1:0]  line_q;        // Infrared, collision enable
    logic        ninth_q;       // Sticky ninth bit
    logic [7:0]  data_q;        // Transmit buffer
    logic        buf_full_q;    // Buffer holds a char
    logic        tx_buffer_empty_flag_q;        // Buffer empty flag
    logic        brk_q;         // Break seen
    logic        berr_q;        // Collision seen
    logic [15:0] cnt_q;         // Modulus counter
    logic        samp_q;        // Sample tick
    logic [3:0]  sub_q;         // Tick within bit
    tx_state_t   state_q;       // Sequencer state
    logic [10:0] shift_q;       // Shift register
    logic [3:0]  bits_q;        // Bits left incl. current
    logic [10:0] nxt_q;         // Char loaded in stop bit
    logic        nxt_v_q;       // nxt_q valid
    logic        pre_q;         // Preamble queued
    logic        txd_q;         // Line output
    logic        rx_m_q;        // Sync stage one
    logic        rx_s_q;        // Sync stage two
    logic [7:0]  brk_cnt_q;     // Low samples in a row
    logic        acc;           // Completing access
    logic        wr;            // Completing write
    logic [4:0]  idx;           // Register index
    logic        te;            // Transmit enable
    logic        len9;          // Nine-bit chars
    logic        infrared_enable;          // Infrared coding
    logic        bit_end;       // Last tick of a bit
    logic        boundary;      // Frame boundary
    logic        can_send;      // Buffer ready to go
    logic        mid_xfer;      // Load in stop bit
    logic        idle_xfer;     // Load at boundary
    logic        xfer_ev;       // Any buffer transfer
    logic        abort_ev;      // Collision abort
    logic        load_pre;      // Preamble load
    logic        te_rise;       // Enable 0 to 1 write
    logic        dl_wr;         // Data low write
    logic        sr_wr;         // Status write
    logic [3:0]  frame_len;     // Bits per frame
    logic        line_bit;      // NRZ level now

    assign acc  = psel && penable && pready_q;
    assign wr   = acc && pwrite && mapped(paddr);
    assign idx  = paddr[6:2];
    assign te   = ctrl_two_q[`CR2_TE];
    assign len9 = ctrl_one_q.char_len9;
    assign infrared_enable = line_q[`LC_INFRARED_ENABLE];
    assign dl_wr = wr && (idx == `IDX_DATA_LOW);
    assign sr_wr = wr && (idx == `IDX_STATUS_ONE);
    assign te_rise = wr && (idx == `IDX_CTRL_TWO)
                  && pwdata[`CR2_TE] && !te;
    assign frame_len = len9 ? `FRAME_LEN9 : `FRAME_LEN8;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------

    // Read mux; unused bits read zero
    always_comb begin
        rdata_d = 8'h00;
        case (idx)
            `IDX_BAUD_HIGH:  rdata_d = baud_hi_q;
            `IDX_BAUD_LOW:   rdata_d = baud_lo_q;
            `IDX_CTRL_ONE:   rdata_d = ctrl_one_q;
            `IDX_CTRL_TWO:   rdata_d = ctrl_two_q;
            `IDX_STATUS_ONE: begin
                rdata_d[`SR1_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag_q;
                rdata_d[`SR1_TC]   = (state_q == ST_IDLE);
                rdata_d[`SR1_BRK]  = brk_q;
                rdata_d[`SR1_BERR] = berr_q;
            end
            `IDX_LINE_CTRL:  rdata_d = {6'h00, line_q};
            default:         rdata_d = 8'h00; // Data is write-only
        endcase
    end

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q
                      && !mapped(paddr);
            if (psel && penable && !pready_q) begin
                prdata_q <= mapped(paddr) ? {24'h000000, rdata_d}
                                          : 32'h00000000;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_hi_q  <= `REG_RESET;
            baud_lo_q  <= `REG_RESET;
            div_q      <= `DIV_RESET;
            ctrl_one_q <= `REG_RESET;
            ctrl_two_q <= `REG_RESET;
            line_q     <= 2'h0;
            ninth_q    <= 1'b0;
        end else if (wr) begin
            case (idx)
                // High byte only staged until the low write
                `IDX_BAUD_HIGH: baud_hi_q <= pwdata[7:0];
                `IDX_BAUD_LOW: begin
                    baud_lo_q <= pwdata[7:0];
                    div_q     <= {baud_hi_q, pwdata[7:0]};
                end
                `IDX_CTRL_ONE:  ctrl_one_q <= pwdata[7:0];
                `IDX_CTRL_TWO:  ctrl_two_q <= pwdata[7:0];
                `IDX_LINE_CTRL: line_q     <= pwdata[1:0];
                `IDX_DATA_HIGH: ninth_q    <= pwdata[`DH_T8];
                default: ;
            endcase
        end
    end

    // Buffer contents
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= 8'h00;
        end else if (dl_wr) begin
            data_q <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // Baud generator
    // ----------------------------------------

    // Counter runs 1..div; tick on wrap gives pclk/div
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= 16'h0001;
            samp_q <= 1'b0;
        end else if (div_q == 16'h0000) begin
            cnt_q  <= 16'h0001;
            samp_q <= 1'b0;
        end else if (cnt_q >= div_q) begin
            cnt_q  <= 16'h0001;
            samp_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 16'h0001;
            samp_q <= 1'b0;
        end
    end

    // Sixteen sample ticks per transmit bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_q <= 4'h0;
        end else if (samp_q) begin
            sub_q <= sub_q + 4'h1;
        end
    end

    assign bit_end = samp_q && (sub_q == `LAST_TICK);

    // ----------------------------------------
    // Transmit control events
    // ----------------------------------------
    assign boundary = bit_end
                   && ((state_q == ST_IDLE) || (bits_q == 4'h1));
    assign can_send = te && buf_full_q && !berr_q && !pre_q;
    // Compare line against rxd mid-bit while sending NRZ
    assign abort_ev = line_q[`LC_BERRE] && !infrared_enable && !berr_q
                   && (state_q != ST_IDLE) && samp_q
                   && (sub_q == `CHECK_TICK)
                   && (rx_s_q != shift_q[0]);
    assign mid_xfer = (state_q == ST_FRAME) && (bits_q == 4'h1)
                   && samp_q && (sub_q == `STOP_LOAD_TICK)
                   && can_send && !nxt_v_q && !abort_ev;
    assign idle_xfer = boundary && !nxt_v_q && can_send
                    && !abort_ev;
    assign xfer_ev  = mid_xfer || idle_xfer;
    assign load_pre = boundary && !nxt_v_q && te && pre_q
                   && !berr_q && !abort_ev;

    // Empty flag and buffer state; a transfer wins the flag over a write, a write wins buf_full_q
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buffer_empty_flag_q     <= 1'b1;
            buf_full_q <= 1'b0;
        end else begin
            if (xfer_ev || abort_ev) begin
                tx_buffer_empty_flag_q <= 1'b1;
            end else if (dl_wr) begin
                tx_buffer_empty_flag_q <= 1'b0;
            end
            if (dl_wr) begin
                buf_full_q <= 1'b1;
            end else if (xfer_ev || abort_ev) begin
                buf_full_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Transmit sequencer and shift register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            shift_q <= 11'h7FF;
            bits_q  <= 4'h0;
            nxt_q   <= 11'h7FF;
            nxt_v_q <= 1'b0;
            pre_q   <= 1'b0;
        end else begin
            if (te_rise) begin
                pre_q <= 1'b1;
            end else if (load_pre) begin
                pre_q <= 1'b0;
            end
            if (abort_ev) begin
                // Drop frame and queued char, leave line high
                state_q <= ST_IDLE;
                shift_q <= 11'h7FF;
                nxt_v_q <= 1'b0;
            end else if (mid_xfer) begin
                // Stop bit keeps shifting; char waits in nxt_q
                nxt_q   <= build_frame(data_q, ninth_q, len9,
                           ctrl_one_q.parity_enable_bit,
                           ctrl_one_q.parity_type_bit);
                nxt_v_q <= 1'b1;
            end else if (boundary) begin
                if (nxt_v_q) begin
                    state_q <= ST_FRAME;
                    shift_q <= nxt_q;
                    bits_q  <= frame_len;
                    nxt_v_q <= 1'b0;
                end else if (load_pre) begin
                    state_q <= ST_PREAMBLE;
                    shift_q <= 11'h7FF;
                    bits_q  <= frame_len;
                end else if (idle_xfer) begin
                    state_q <= ST_FRAME;
                    shift_q <= build_frame(data_q, ninth_q, len9,
                               ctrl_one_q.parity_enable_bit,
                               ctrl_one_q.parity_type_bit);
                    bits_q  <= frame_len;
                end else begin
                    state_q <= ST_IDLE;
                    shift_q <= 11'h7FF;
                    bits_q  <= 4'h0;
                end
            end else if (bit_end && (state_q != ST_IDLE)) begin
                shift_q <= {1'b1, shift_q[10:1]};
                bits_q  <= bits_q - 4'h1;
            end
        end
    end

    // ----------------------------------------
    // Line coding
    // ----------------------------------------
    assign line_bit = (state_q == ST_IDLE) ? 1'b1 : shift_q[0];

    // Registered so txd has no glitch from the muxes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txd_q <= 1'b1;
        end else if (infrared_enable) begin
            // Mid-bit pulse, 3/16 wide, only for zeros
            txd_q <= !line_bit && (sub_q >= `IR_FIRST_TICK)
                  && (sub_q <= `IR_LAST_TICK);
        end else begin
            txd_q <= line_bit;
        end
    end

    // ----------------------------------------
    // Receive line watch
    // ----------------------------------------

    // rxd is asynchronous: two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
        end else begin
            rx_m_q <= rxd;
            rx_s_q <= rx_m_q;
        end
    end

    // Count low samples; a full frame of them is a break
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_cnt_q <= 8'h00;
        end else if (samp_q && rx_s_q) begin
            brk_cnt_q <= 8'h00;
        end else if (samp_q && (brk_cnt_q != 8'hFF)) begin
            brk_cnt_q <= brk_cnt_q + 8'h01;
        end
    end

    // Sticky flags, write one to clear; a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_q  <= 1'b0;
            berr_q <= 1'b0;
        end else begin
            if (samp_q && !rx_s_q && (brk_cnt_q ==
                (len9 ? `BRK_LAST9 : `BRK_LAST8))) begin
                brk_q <= 1'b1;
            end else if (sr_wr && pwdata[`SR1_BRK]) begin
                brk_q <= 1'b0;
            end
            if (abort_ev) begin
                berr_q <= 1'b1;
            end else if (!line_q[`LC_BERRE]
                         || (sr_wr && pwdata[`SR1_BERR])) begin
                berr_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata         = prdata_q;
    assign pready         = pready_q;
    assign pslverr        = pslverr_q;
    assign txd            = txd_q;
    assign rx_sample_tick = samp_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic first_q; // Low only in the first cycle after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_q <= 1'b0;
        end else begin
            first_q <= 1'b1;
        end
    end

    sequence s_pre_loaded;
        (state_q == ST_PREAMBLE) && (bits_q == frame_len)
        && shift_q[0];
    endsequence
    sequence s_aborted;
        tx_buffer_empty_flag_q && berr_q && (state_q == ST_IDLE) && !nxt_v_q;
    endsequence

    property p_start_bit;
        @(posedge pclk) disable iff (!presetn)
        (idle_xfer && !infrared_enable) |=> ##1 !txd_q;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("start bit not driven low");

    property p_len8;
        @(posedge pclk) disable iff (!presetn)
        (idle_xfer && !len9) |=> (bits_q == 4'hA);
    endproperty
    a_len8: assert property (p_len8)
        else $error("8-bit frame length wrong");

    property p_len9;
        @(posedge pclk) disable iff (!presetn)
        (idle_xfer && len9) |=> (bits_q == 4'hB);
    endproperty
    a_len9: assert property (p_len9)
        else $error("9-bit frame length wrong");

    property p_div_zero;
        @(posedge pclk) disable iff (!presetn)
        (div_q == 16'h0000)[*2] |-> !samp_q;
    endproperty
    a_div_zero: assert property (p_div_zero)
        else $error("tick while divisor zero");

    property p_high_staged;
        @(posedge pclk) disable iff (!presetn)
        (wr && idx == `IDX_BAUD_HIGH) |=> $stable(div_q);
    endproperty
    a_high_staged: assert property (p_high_staged)
        else $error("divisor changed by high write");

    property p_shift_on_tick;
        @(posedge pclk) disable iff (!presetn)
        (!samp_q && !abort_ev) |=> $stable(shift_q) && $stable(bits_q);
    endproperty
    a_shift_on_tick: assert property (p_shift_on_tick)
        else $error("shift outside bit tick");

    property p_mid_xfer;
        @(posedge pclk) disable iff (!presetn)
        mid_xfer |=> tx_buffer_empty_flag_q && nxt_v_q && (sub_q == 4'h9);
    endproperty
    a_mid_xfer: assert property (p_mid_xfer)
        else $error("stop-bit transfer wrong");

    property p_preamble;
        @(posedge pclk) disable iff (!presetn)
        load_pre |=> s_pre_loaded;
    endproperty
    a_preamble: assert property (p_preamble)
        else $error("preamble not loaded");

    property p_abort;
        @(posedge pclk) disable iff (!presetn)
        abort_ev |=> s_aborted;
    endproperty
    a_abort: assert property (p_abort)
        else $error("collision did not abort");

    property p_tx_buffer_empty_flag_reset;
        @(posedge pclk) disable iff (!presetn)
        !first_q |-> tx_buffer_empty_flag_q;
    endproperty
    a_tx_buffer_empty_flag_reset: assert property (p_tx_buffer_empty_flag_reset)
        else $error("empty flag not set after reset");

    property p_idle_high;
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_IDLE && !infrared_enable)[*2] |-> txd_q;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("idle line not high");

endmodule // async_serial_tx

/* tb/serial_remote_rx.sv */
/*
 * Remote serial receiver standing on the transmit line.
 * Assumes NRZ coding and a shared line that echoes txd back.
 */
module serial_remote_rx (
    input  wire logic       pclk,
    input  wire logic       txd,
    input  wire logic [3:0] div,
    input  wire logic       len9,
    input  wire logic       jam,
    output logic            rxd,
    output logic [8:0]      rx_data,
    output int              rx_count
);
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------
    // Line echo and frame decoder
    // -------------------------------
    // A shared bus reads back its own driver; jam holds it recessive high
    assign rxd = txd | jam;
    // Sample each bit at its middle; a bad stop bit spoils the data
    initial begin
        rx_count = 0;
        rx_data  = '0;
        forever begin
            @(negedge txd);
            repeat (8 * div) @(posedge pclk);
            if (txd === 1'b0) begin
                rx_data = '0;
                for (int i = 0; i < (len9 ? 9 : 8); i++) begin
                    repeat (16 * div) @(posedge pclk);
                    rx_data[i] = txd;
                end
                repeat (16 * div) @(posedge pclk);
                if (txd !== 1'b1) begin
                    rx_data = 'x;
                end
                rx_count++;
            end
        end
    end
endmodule // serial_remote_rx

/* tb/async_serial_tx_test.sv */
/*
 * Self-checking bench for the serial transmitter.
 * Assumes the APB slave answers within 50 cycles.
 */
module async_serial_tx_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, txd, rxd, tick, len9, rerr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  div;
    logic        jam;  // Fakes a colliding node on the line
    logic [8:0]  rx_data;
    int          rx_count, failures, check_count, n;
    async_serial_tx async_serial_tx_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .rx_sample_tick(tick));
    serial_remote_rx serial_remote_rx_i (.pclk(pclk), .txd(txd), .div(div), .len9(len9),
        .jam(jam), .rxd(rxd), .rx_data(rx_data), .rx_count(rx_count));
    // -------------------------------
    // Tasks
    // -------------------------------
    task automatic end_sim();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            failures++;
            end_sim();
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Cycles until the next sample tick, 200 meaning none came
    task automatic wait_tick();
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (tick !== 1'b1 && n < 200);
    endtask
    task automatic wait_rx(input int c);
        n = 0;
        while (rx_count < c && n < 9000) begin
            @(posedge pclk);
            n++;
        end
        check(rx_count, c);
        if (rx_count < c) begin
            end_sim();
        end
    endtask
    // -------------------------------
    // Clock, reset and sequence
    // -------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, len9, jam} = '0;
        {paddr, pwdata, failures, check_count} = '0;
        div = 4'h2;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(txd, 1);
        apb(0, 8'h10, 0);
        check(rd[7], 1);
        apb(0, 8'h20, 0);
        check(rerr, 1);
        wait_tick();
        check(n, 200);
        apb(1, 8'h00, 0);
        apb(1, 8'h04, 32'h02);
        wait_tick();
        wait_tick();
        check(n, 2);
        apb(1, 8'h00, 32'h01);
        wait_tick();
        wait_tick();
        check(n, 2);
        apb(1, 8'h00, 0);
        apb(1, 8'h04, 32'h02);
        // Enable, then queue a byte at once: the idle preamble must lead
        apb(1, 8'h08, 0);
        apb(1, 8'h0C, 32'h08);
        apb(1, 8'h1C, 32'hA5);
        apb(0, 8'h10, 0);
        check(rd[7], 0);
        n = 0;
        while (txd !== 1'b0 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 2000) begin
            failures++;
            end_sim();
        end
        check(n >= 290, 1);
        wait_rx(1);
        check(rx_data, 32'hA5);
        apb(0, 8'h10, 0);
        check(rd[7], 1);
        apb(1, 8'h08, 32'h10);
        len9 <= 1'b1;
        apb(1, 8'h18, 32'h40);
        apb(1, 8'h1C, 32'h3C);
        wait_rx(2);
        check(rx_data, 32'h13C);
        apb(0, 8'h10, 0);
        check(rd[7], 1);
        apb(1, 8'h1C, 32'h55);
        wait_rx(3);
        check(rx_data, 32'h155);
        // Even parity replaces d7; the second byte waits in the stop bit
        apb(1, 8'h08, 32'h02);
        len9 <= 1'b0;
        apb(1, 8'h1C, 32'h07);
        repeat (40) @(posedge pclk);
        apb(0, 8'h10, 0);
        check(rd[7], 1);
        apb(1, 8'h1C, 32'h01);
        wait_rx(4);
        check(rx_data, 32'h87);
        wait_rx(5);
        check(rx_data, 32'h81);
        // Collision: the line reads back high during the start bit
        apb(1, 8'h14, 32'h02);
        jam <= 1'b1;
        apb(1, 8'h1C, 32'h0F);
        repeat (100) @(posedge pclk);
        apb(0, 8'h10, 0);
        check(rd, 32'hC1);
        check(txd, 1);
        end_sim();
    end
endmodule // async_serial_tx_test
